//--- rtl/rbmo_defs.svh
// rbmo_defs.svh: register offsets, fields, reset values and link timing counts
// assumes: included by bare name; slot numbers are 11 bits wide
// How it works
// - multiplexed formats only while enable bit set
// - 00 bit-interleaves four channels at 12.352 MHz
// - 01 bit-interleaves four channels at 16.384 MHz
// - bit modes: sync high on framing bit only
// - 10 byte-interleaves four channels, HMVIP framing
// - HMVIP sync: two bits either side
// - 11 byte-interleaves four channels, H.100 framing
// - H.100 sync: one bit either side
// - backplane supplies the serial clock input
// - backplane drives frame sync per format
// - serial data changes on serial clock rise
`ifndef RBMO_DEFS_SVH
`define RBMO_DEFS_SVH
`define RBMO_OFS_CTRL     4'h0
`define RBMO_OFS_STAT     4'h1
`define RBMO_CTRL_RST     8'h00
`define RBMO_BIT_MUXEN    2
`define RBMO_STAT_UNDER   0
`define RBMO_STAT_SYNCERR 1
`define RBMO_STAT_LOCK    2
`define RBMO_LAST_12      11'h607
`define RBMO_LAST_16      11'h7FF
`define RBMO_HALF_12      5
`define RBMO_HALF_16      4
`define RBMO_FIFO_DEPTH   8
`endif

//--- rtl/rbmo_pkg.sv
// rbmo_pkg: speed codes and the slot arithmetic both link ends share
// assumes: rbmo_defs.svh is on the include path
`include "rbmo_defs.svh"
package rbmo_pkg;
    typedef enum logic [1:0] {
        spd_bit12 = 2'b00,
        spd_bit16 = 2'b01,
        spd_hmvip = 2'b10,
        spd_h100  = 2'b11
    } rbmo_speed_t;

    // last slot of a frame
    function automatic logic [10:0] rbmo_last(input rbmo_speed_t m);
        return (m == spd_bit12) ? `RBMO_LAST_12 : `RBMO_LAST_16;
    endfunction

    // level the frame sync has while slot s is on the wire
    function automatic logic rbmo_sync_at(input rbmo_speed_t m, input logic [10:0] s);
        logic [10:0] l;
        l = rbmo_last(m);
        case (m)
            spd_hmvip: return (s >= l - 11'h001) || (s <= 11'h001);
            spd_h100:  return (s == l) || (s == 11'h000);
            default:   return s == 11'h000;
        endcase
    endfunction

    // slot on which the sync pulse begins
    function automatic logic [10:0] rbmo_sync_slot(input rbmo_speed_t m);
        case (m)
            spd_hmvip: return rbmo_last(m) - 11'h001;
            spd_h100:  return rbmo_last(m);
            default:   return 11'h000;
        endcase
    endfunction
endpackage

//--- rtl/rbmo_if.sv
// rbmo_if: receive backplane link between the framer end and the backplane end
// assumes: all three wires are one-way; the testbench joins the two ends here
`timescale 1ns/1ps
interface rbmo_if;
    logic rx_serial_clock;
    logic rx_frame_sync;
    logic rx_serial_out;
    modport device (
        input  rx_serial_clock,
        input  rx_frame_sync,
        output rx_serial_out
    );
    modport backplane (
        output rx_serial_clock,
        output rx_frame_sync,
        input  rx_serial_out
    );
endinterface

//--- rtl/rbmo_fifo.sv
// rbmo_fifo: word FIFO with valid/ready on both sides
// assumes: DEPTH is a power of two; read data is valid while out_valid is high
`timescale 1ns/1ps
`include "rbmo_defs.svh"
module rbmo_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = `RBMO_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // fill side
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    // drain side
    output logic      [W-1:0] out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          push;
    logic          pop;

    assign push     = in_valid & in_ready;
    assign pop      = out_valid & out_ready;
    assign out_data = mem[rp_r];

    always_comb begin
        cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    // flags are registered from the next count so both ports come from flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r      <= '0;
            rp_r      <= '0;
            cnt_r     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            wp_r      <= push ? wp_r + AW'(1) : wp_r;
            rp_r      <= pop ? rp_r + AW'(1) : rp_r;
            cnt_r     <= cnt_nxt;
            in_ready  <= cnt_nxt != (AW+1)'(DEPTH);
            out_valid <= cnt_nxt != '0;
        end
    end
endmodule // rbmo_fifo

//--- rtl/rbmo_device.sv
// rbmo_device: framer end; multiplexes four receive channels onto the backplane
// assumes: backplane end makes clock and sync; clk samples both through two flops
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "rbmo_defs.svh"
module rbmo_device #(
    parameter int DEPTH = `RBMO_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register port
    input  wire logic [3:0]  sw_addr,
    input  wire logic [7:0]  sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [7:0]  sw_rdata,
    // byte column: channel n in bits 8n+7..8n, msb sent first
    input  wire logic [31:0] in_data,
    input  wire logic        in_valid,
    output logic             in_ready,
    // backplane link
    rbmo_if.device           link
);
    rbmo_pkg::rbmo_speed_t speed_r;
    logic                  mux_en_r;
    logic                  underrun_r;
    logic                  sync_err_r;
    logic                  locked_r;
    logic [2:0]            sclk_q;
    logic [1:0]            sync_q;
    logic                  sync_prev_r;
    logic [10:0]           slot_r;
    logic [10:0]           slot_run;
    logic [10:0]           slot_nxt;
    logic [31:0]           word_r;
    logic [31:0]           cur_word;
    logic [31:0]           fifo_data;
    logic                  fifo_valid;
    logic                  fifo_ready;
    logic [4:0]            k;
    logic [1:0]            ch;
    logic [2:0]            b;
    logic [4:0]            idx;
    logic                  rise;
    logic                  sync_rise;
    logic                  fetch;
    logic                  sync_bad;
    logic                  out_r;
    logic                  ctrl_wr;
    logic                  stat_wr;

    assign link.rx_serial_out = out_r;

    rbmo_fifo #(
        .W     (32),
        .DEPTH (DEPTH)
    ) rbmo_fifo_inst (
        .clk       (clk),
        .rst       (rst),
        .in_data   (in_data),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready)
    );

    // link pins are foreign to clk: two flops before anything looks at them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_q <= '0;
            sync_q <= '0;
        end else begin
            sclk_q <= {sclk_q[1:0], link.rx_serial_clock};
            sync_q <= {sync_q[0], link.rx_frame_sync};
        end
    end

    assign rise      = sclk_q[1] & ~sclk_q[2];
    assign sync_rise = sync_q[1] & ~sync_prev_r;

    // slot counter: free running, realigned to the sync pulse start
    always_comb begin
        if (slot_r >= rbmo_pkg::rbmo_last(speed_r)) begin
            slot_run = '0;
        end else begin
            slot_run = slot_r + 11'h001;
        end
        if (sync_rise) begin
            slot_nxt = rbmo_pkg::rbmo_sync_slot(speed_r);
        end else begin
            slot_nxt = slot_run;
        end
    end

    // a new column is taken at every 32-slot boundary; an empty FIFO sends zeros
    assign k          = slot_nxt[4:0];
    assign fetch      = rise & mux_en_r & (k == 5'h00);
    assign fifo_ready = fetch;
    assign cur_word   = (k == 5'h00) ? (fifo_valid ? fifo_data : 32'h0000_0000) : word_r;

    // bit modes rotate channels every slot, byte modes every eight slots
    always_comb begin
        if (speed_r[1] == 1'b0) begin
            ch = k[1:0];
            b  = k[4:2];
        end else begin
            ch = k[4:3];
            b  = k[2:0];
        end
        idx = {ch, 3'h7 - b};
    end

    assign sync_bad = locked_r & (sync_q[1] != rbmo_pkg::rbmo_sync_at(speed_r, slot_run));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slot_r <= 11'h7FF;
        end else if (!mux_en_r) begin
            slot_r <= rbmo_pkg::rbmo_last(speed_r);
        end else if (rise) begin
            slot_r <= slot_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_prev_r <= 1'b0;
        end else if (!mux_en_r) begin
            sync_prev_r <= 1'b0;
        end else if (rise) begin
            sync_prev_r <= sync_q[1];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_r <= 32'h0000_0000;
        end else if (!mux_en_r) begin
            word_r <= 32'h0000_0000;
        end else if (rise) begin
            word_r <= cur_word;
        end
    end

    // while enabled the bit moves only on a detected rise, so it is settled long before the far end samples it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_r <= 1'b0;
        end else if (!mux_en_r) begin
            out_r <= 1'b0;
        end else if (rise) begin
            out_r <= cur_word[idx];
        end
    end

    assign ctrl_wr = sw_wr & (sw_addr == `RBMO_OFS_CTRL);
    assign stat_wr = sw_wr & (sw_addr == `RBMO_OFS_STAT);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            speed_r  <= rbmo_pkg::rbmo_speed_t'(2'(`RBMO_CTRL_RST));
            mux_en_r <= 1'b0;
        end else if (ctrl_wr) begin
            speed_r  <= rbmo_pkg::rbmo_speed_t'(sw_wdata[1:0]);
            mux_en_r <= sw_wdata[`RBMO_BIT_MUXEN];
        end
    end

    // lock follows the first sync pulse seen while enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            locked_r <= 1'b0;
        end else if (!mux_en_r) begin
            locked_r <= 1'b0;
        end else if (rise & sync_rise) begin
            locked_r <= 1'b1;
        end
    end

    // sticky flags clear on write-one; a set in the same cycle wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            underrun_r <= 1'b0;
            sync_err_r <= 1'b0;
        end else begin
            if (fetch & ~fifo_valid) begin
                underrun_r <= 1'b1;
            end else if (stat_wr & sw_wdata[`RBMO_STAT_UNDER]) begin
                underrun_r <= 1'b0;
            end
            if (rise & mux_en_r & sync_bad) begin
                sync_err_r <= 1'b1;
            end else if (stat_wr & sw_wdata[`RBMO_STAT_SYNCERR]) begin
                sync_err_r <= 1'b0;
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sw_rdata <= 8'h00;
        end else if (sw_rd) begin
            case (sw_addr)
                `RBMO_OFS_CTRL: sw_rdata <= {5'h00, mux_en_r, speed_r};
                `RBMO_OFS_STAT: sw_rdata <= {5'h00, locked_r, sync_err_r, underrun_r};
                default:        sw_rdata <= 8'h00;
            endcase
        end else begin
            sw_rdata <= 8'h00;
        end
    end
endmodule // rbmo_device

//--- rtl/rbmo_backplane.sv
// rbmo_backplane: backplane end; makes serial clock and frame sync, takes the data
// assumes: the framer end answers a clock rise within three clk cycles
`timescale 1ns/1ps
`include "rbmo_defs.svh"
module rbmo_backplane #(
    parameter int HALF_12 = `RBMO_HALF_12,
    parameter int HALF_16 = `RBMO_HALF_16
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // control
    input  wire logic                  run,
    input  wire rbmo_pkg::rbmo_speed_t speed,
    // received bits
    output logic                       rx_bit,
    output logic                       rx_bit_valid,
    output logic      [10:0]           rx_slot,
    // backplane link
    rbmo_if.backplane                  link
);
    logic [7:0]  div_r;
    logic [7:0]  half;
    logic        sclk_r;
    logic        sync_r;
    logic        armed_r;
    logic [10:0] cur_r;
    logic [10:0] nxt;
    logic [1:0]  ser_q;
    logic        toggle;

    assign link.rx_serial_clock = sclk_r;
    assign link.rx_frame_sync   = sync_r;

    // clock period is a divider of clk, so the link rate is scaled in simulation
    assign half   = (speed == rbmo_pkg::spd_bit12) ? 8'(HALF_12) : 8'(HALF_16);
    assign toggle = div_r == half - 8'h01;
    assign nxt    = (cur_r >= rbmo_pkg::rbmo_last(speed)) ? 11'h000 : cur_r + 11'h001;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ser_q <= '0;
        end else begin
            ser_q <= {ser_q[0], link.rx_serial_out};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_r   <= 8'h00;
            sclk_r  <= 1'b0;
            sync_r  <= 1'b0;
            armed_r <= 1'b0;
            cur_r   <= 11'h7FF;
        end else if (!run) begin
            div_r   <= 8'h00;
            sclk_r  <= 1'b0;
            sync_r  <= 1'b0;
            armed_r <= 1'b0;
            cur_r   <= rbmo_pkg::rbmo_last(speed);
        end else begin
            div_r  <= toggle ? 8'h00 : div_r + 8'h01;
            sclk_r <= toggle ? ~sclk_r : sclk_r;
            if (toggle & sclk_r) begin
                // falling edge: set the sync level for the next slot
                armed_r <= armed_r | (nxt == rbmo_pkg::rbmo_sync_slot(speed));
                sync_r  <= rbmo_pkg::rbmo_sync_at(speed, nxt) &
                           (armed_r | (nxt == rbmo_pkg::rbmo_sync_slot(speed)));
            end
            if (toggle & ~sclk_r) begin
                cur_r <= nxt;
            end
        end
    end

    // sample late in the low phase, well after the framer has moved its data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_bit       <= 1'b0;
            rx_bit_valid <= 1'b0;
            rx_slot      <= 11'h000;
        end else begin
            rx_bit_valid <= run & ~sclk_r & (div_r == half - 8'h02);
            if (run & ~sclk_r & (div_r == half - 8'h02)) begin
                rx_bit  <= ser_q[1];
                rx_slot <= cur_r;
            end
        end
    end
endmodule // rbmo_backplane

//--- test/rbmo_chk.sv
// rbmo_chk: timing and framing checks on the receive backplane link
// assumes: both serial half periods are 4 clk, so one slot is 8 clk
`timescale 1ns/1ps
module rbmo_chk (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    // backplane control
    input wire logic                  run,
    input wire rbmo_pkg::rbmo_speed_t speed,
    // link
    input wire logic                  rx_serial_clock,
    input wire logic                  rx_frame_sync,
    input wire logic                  rx_serial_out
);
    logic [15:0] hi_cnt;
    logic [15:0] gap_cnt;
    logic [15:0] exp_len;
    logic [15:0] exp_gap;
    logic        sync_d;
    logic        seen;

    always_comb begin
        case (speed)
            rbmo_pkg::spd_hmvip: exp_len = 16'h0020;
            rbmo_pkg::spd_h100:  exp_len = 16'h0010;
            default:             exp_len = 16'h0008;
        endcase
    end
    assign exp_gap = (speed == rbmo_pkg::spd_bit12) ? 16'h3040 : 16'h4000;

    // counters restart whenever the clock is stopped, so a cut pulse is never judged
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hi_cnt <= 16'h0000;
        end else begin
            hi_cnt <= (rx_frame_sync && run) ? hi_cnt + 16'h0001 : 16'h0000;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_d  <= 1'b0;
            gap_cnt <= 16'h0000;
            seen    <= 1'b0;
        end else begin
            sync_d  <= rx_frame_sync;
            seen    <= run && (seen || (rx_frame_sync && !sync_d));
            gap_cnt <= (!run || (rx_frame_sync && !sync_d)) ? 16'h0001 : gap_cnt + 16'h0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !run);

    sequence s_high_half;
        rx_serial_clock[*4];
    endsequence
    sequence s_low_half;
        !rx_serial_clock[*4];
    endsequence

    a_clk_period: assert property ($rose(rx_serial_clock) |-> s_high_half ##1 s_low_half ##1 rx_serial_clock)
        else $error("serial clock period wrong");
    a_data_on_rise: assert property ($changed(rx_serial_out) |->
        rx_serial_clock && $past(rx_serial_clock, 3) && !$past(rx_serial_clock, 4))
        else $error("serial data changed away from clock rise");
    a_data_low_stable: assert property (!rx_serial_clock |-> $stable(rx_serial_out))
        else $error("serial data moved in low phase");
    a_sync_len: assert property ($fell(rx_frame_sync) |-> hi_cnt == exp_len)
        else $error("frame sync pulse length wrong");
    a_sync_bit_slot: assert property ($rose(rx_frame_sync) && !speed[1] |-> rx_frame_sync[*8] ##1 !rx_frame_sync)
        else $error("bit mode sync not one slot");
    a_frame_gap: assert property (rx_frame_sync && !sync_d && seen |-> gap_cnt == exp_gap)
        else $error("frame length wrong");
    a_sync_on_fall: assert property ($changed(rx_frame_sync) |-> !rx_serial_clock && $past(rx_serial_clock))
        else $error("frame sync moved off clock fall");
    a_sync_bounded: assert property (rx_frame_sync |-> hi_cnt < 16'h0020)
        else $error("frame sync held too long");
endmodule // rbmo_chk

//--- test/rbmo_tb.sv
// rbmo_tb: joins framer end and backplane end, drives registers and data
// assumes: backplane halves both set to 4 clk to keep frames short
`timescale 1ns/1ps
module rbmo_tb;
    localparam logic [31:0] WORD = 32'h8C35E15A;
    logic                  clk = 1'b0, rst = 1'b1, sw_wr = 1'b0, sw_rd = 1'b0, in_valid = 1'b0, run = 1'b0;
    logic                  in_ready, rx_bit, rx_bit_valid;
    logic [3:0]            sw_addr = 4'h0;
    logic [7:0]            sw_wdata = 8'h00, sw_rdata, v;
    logic [31:0]           in_data = WORD;
    logic [10:0]           rx_slot;
    rbmo_pkg::rbmo_speed_t speed = rbmo_pkg::spd_bit12;
    int                    mismatches = 0, compares = 0;

    rbmo_if link ();
    rbmo_device rbmo_device_inst (.clk(clk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .in_data(in_data), .in_valid(in_valid),
        .in_ready(in_ready), .link(link));
    rbmo_backplane #(.HALF_12(4), .HALF_16(4)) rbmo_backplane_inst (.clk(clk), .rst(rst), .run(run),
        .speed(speed), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_slot(rx_slot), .link(link));
    rbmo_chk rbmo_chk_inst (.clk(clk), .rst(rst), .run(run), .speed(speed),
        .rx_serial_clock(link.rx_serial_clock), .rx_frame_sync(link.rx_frame_sync),
        .rx_serial_out(link.rx_serial_out));

    always #25 clk = ~clk;

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_wr    <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        @(negedge clk);
        d = sw_rdata;
    endtask

    // compare received bits with the slot's place in the word; disabled mux must send 0
    task automatic check_bits(input int n, input logic [1:0] m, input logic en);
        int t;
        int k;
        int idx;
        for (int i = 0; i < n; i++) begin
            t = 0;
            @(negedge clk);
            while (rx_bit_valid !== 1'b1 && t < 100) begin
                @(negedge clk);
                t++;
            end
            k = int'(rx_slot[4:0]);
            idx = m[1] ? 8 * (k / 8) + 7 - (k % 8) : 8 * (k % 4) + 7 - (k / 4);
            chk("rx_bit", {30'h0, rx_bit_valid, rx_bit}, {30'h0, 1'b1, en & WORD[idx]});
        end
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(4'h0, v);
        chk("ctrl_reset", v, 8'h00);
        rd(4'hF, v);
        chk("unmapped", v, 8'h00);
        wr(4'h0, 8'hFB);
        rd(4'h0, v);
        chk("ctrl_rw", v, 8'h03);
        wr(4'h0, 8'h00);
        @(posedge clk);
        in_valid <= 1'b1;
        repeat (12) @(posedge clk);
        @(negedge clk);
        chk("fifo_full", in_ready, 1'b0);
        @(posedge clk);
        run <= 1'b1;
        check_bits(64, 2'b00, 1'b0);
        chk("fifo_held", in_ready, 1'b0);
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            run <= 1'b0;
            wr(4'h0, 8'h00);
            wr(4'h1, 8'h03);
            speed <= rbmo_pkg::rbmo_speed_t'(m[1:0]);
            wr(4'h0, {5'h00, 1'b1, m[1:0]});
            rd(4'h0, v);
            chk("ctrl_mode", v, {5'h00, 1'b1, m[1:0]});
            @(posedge clk);
            run <= 1'b1;
            for (int i = 0; i < 400; i++) begin
                rd(4'h1, v);
                if (v[2] === 1'b1) break;
                repeat (100) @(posedge clk);
            end
            chk("locked", {31'h0, v[2]}, 32'h1);
            check_bits(96, m[1:0], 1'b1);
            // one more full frame lets the frame length check see two sync pulses
            if (m == 0) repeat (13000) @(posedge clk);
            rd(4'h1, v);
            chk("status_flags", {30'h0, v[1:0]}, 32'h0);
        end
        // starve the FIFO: every column after the last word goes out as zeros
        @(posedge clk);
        in_valid <= 1'b0;
        repeat (3000) @(posedge clk);
        check_bits(32, 2'b11, 1'b0);
        rd(4'h1, v);
        chk("underrun", {31'h0, v[0]}, 32'h1);
        report_and_stop;
    end

    initial begin
        repeat (96000) @(posedge clk);
        mismatches++;
        report_and_stop;
    end
endmodule // rbmo_tb
